// >>> rtc_pkg.sv
package rtc_pkg;

  // Register byte addresses on the two-wire bus.
  localparam logic [7:0] ADDR_CTRL2 = 8'h01;
  localparam logic [7:0] ADDR_SECONDS = 8'h02;
  localparam logic [7:0] ADDR_MINUTES = 8'h03;
  localparam logic [7:0] ADDR_HOURS = 8'h04;

  // Seven-bit bus address of the device (write A2h, read A3h).
  localparam logic [6:0] SLAVE_ADDR = 7'h51;

  // Control/status field positions.
  localparam int BIT_PULSE_SEL = 4;
  localparam int BIT_ALARM_FLAG = 3;
  localparam int BIT_TIMER_FLAG = 2;
  localparam int BIT_ALARM_IE = 1;
  localparam int BIT_TIMER_IE = 0;
  localparam int BIT_LOW_VOLTAGE = 7;

  // Implemented bits of each register; the rest read as zero, except seconds bit 7, the integrity flag.
  localparam logic [7:0] CTRL2_MASK = 8'h1F;
  localparam logic [7:0] SECONDS_MASK = 8'h7F;
  localparam logic [7:0] MINUTES_MASK = 8'h7F;
  localparam logic [7:0] HOURS_MASK = 8'h3F;

  // Time counter stages, seconds first.
  localparam int TIME_STAGES = 3;
  localparam logic [2:0][7:0] TIME_ADDR = {ADDR_HOURS, ADDR_MINUTES, ADDR_SECONDS};
  localparam logic [2:0][7:0] TIME_MASK = {HOURS_MASK, MINUTES_MASK, SECONDS_MASK};
  localparam logic [2:0][7:0] TIME_LIMIT = {8'h23, 8'h59, 8'h59};
  localparam logic [7:0] TIME_RESET = 8'h00;
  localparam logic [3:0] BCD_UNIT_MAX = 4'h9;
  localparam logic [3:0] BCD_ONE = 4'h1;

  // Reset value of the integrity flag: time untrusted at start-up.
  localparam logic LOW_VOLTAGE_RESET = 1'b1;

  // Clock rate and pulse width denominators (width = 1/DEN seconds).
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned PULSE_DEN_8192 = 8192;
  localparam int unsigned PULSE_DEN_4096 = 4096;
  localparam int unsigned PULSE_DEN_128 = 128;
  localparam int unsigned PULSE_DEN_64 = 64;

  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Countdown timer source clock.
  typedef enum logic [1:0] {
    SRC_4096HZ,
    SRC_64HZ,
    SRC_1HZ,
    SRC_1_60HZ
  } timer_src_e;

  // One register write taken from the bus.
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } bus_write_s;

  // Two-wire slave states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_WR_BYTE,
    ST_ACK_WR,
    ST_RD_BYTE,
    ST_RD_ACK,
    ST_WAIT_STOP
  } bus_state_e;

endpackage : rtc_pkg

// >>> bcd_incr.sv
module bcd_incr (
  // Current and limit value, two BCD digits
  input wire logic [7:0] value,
  input wire logic [7:0] limit,
  // Incremented value and carry out
  output logic [7:0] next_value,
  output logic wrap
);

  // A value at or past the limit wraps, so an out-of-range host write recovers.
  always_comb begin
    wrap = (value >= limit);
    if (wrap) begin
      next_value = rtc_pkg::TIME_RESET;
    end else if (value[3:0] >= rtc_pkg::BCD_UNIT_MAX) begin
      next_value = {value[7:4] + rtc_pkg::BCD_ONE, 4'h0};
    end else begin
      next_value = {value[7:4], value[3:0] + rtc_pkg::BCD_ONE};
    end
  end

endmodule : bcd_incr

// >>> rtc_core.sv
//Contract
// - Level mode: interrupt active while timer flag set and timer enable on.
// - Pulse mode: timer interrupts are pulses, gated by timer enable.
// - Alarm flag with alarm enable holds interrupt active in any mode.
// - Alarm event sets alarm flag, bit 3, read back as one.
// - End of countdown sets timer flag, bit 2.
// - Flags hold until written; a write ANDs each flag with its bit.
// - Enables gate alarm flag and timer flag, or timer pulse in pulse mode; interrupt is OR of both gated conditions.
// - Pulse width 1/8192 or 1/4096 at 4096 Hz, 1/128 at 64 Hz, n=1.
// - Pulse width 1/64 s at 64 Hz n>1, and at 1 Hz and 1/60 Hz.
// - In pulse mode timer flag and interrupt turn active together.
// - A loaded count of zero stops the timer; no events follow.
// - Seconds bit 7 is the integrity flag, one at start-up.
// - Low supply sets integrity flag; only a host write clears it.
// - A stopped oscillator also sets the integrity flag.
// - Seconds in BCD: tens 0-5 in bits 6-4, units 0-9 below.
// - Minutes in BCD: tens 0-5 in bits 6-4, bit 7 unused.
// - Hours in BCD: tens 0-2 in bits 5-4, bits 7-6 unused.
// - Bus access blocks counting; one pending tick is applied afterwards.
// - Clock-stop clears the divider and halts counting.
module rtc_core #(
  parameter int unsigned TICK_CYCLES = rtc_pkg::CLK_HZ,
  parameter int unsigned PULSE_8192_CYCLES = rtc_pkg::CLK_HZ / rtc_pkg::PULSE_DEN_8192,
  parameter int unsigned PULSE_4096_CYCLES = rtc_pkg::CLK_HZ / rtc_pkg::PULSE_DEN_4096,
  parameter int unsigned PULSE_128_CYCLES = rtc_pkg::CLK_HZ / rtc_pkg::PULSE_DEN_128,
  parameter int unsigned PULSE_64_CYCLES = rtc_pkg::CLK_HZ / rtc_pkg::PULSE_DEN_64
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Two-wire bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Open-drain interrupt pin
  output logic int_out,
  output logic int_oe,
  // Alarm compare and countdown timer
  input wire logic alarm_event,
  input wire logic timer_done,
  input wire rtc_pkg::timer_src_e timer_src,
  input wire logic [7:0] timer_count,
  // Supply, oscillator and clock-stop pins
  input wire logic supply_low,
  input wire logic osc_stopped,
  input wire logic clock_stop
);

  // Pin synchronisers; stage one feeds only stage two.
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_s, sda_s, supply_low_s, osc_stopped_s, clock_stop_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 5'h03;
      sync2_reg <= 5'h03;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {clock_stop, osc_stopped, supply_low, sda_in, scl_in};
      sync2_reg <= sync1_reg;
      scl_d_reg <= sync2_reg[0];
      sda_d_reg <= sync2_reg[1];
    end
  end

  assign scl_s = sync2_reg[0];
  assign sda_s = sync2_reg[1];
  assign supply_low_s = sync2_reg[2];
  assign osc_stopped_s = sync2_reg[3];
  assign clock_stop_s = sync2_reg[4];

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // Register state.
  logic pulse_sel_reg, alarm_flag_reg, timer_flag_reg, alarm_ie_reg, timer_ie_reg;
  logic low_voltage_reg;
  logic [7:0] time_reg [rtc_pkg::TIME_STAGES];
  logic [7:0] rd_data;
  logic [7:0] ptr_reg;
  rtc_pkg::bus_write_s wr_reg;

  // Read decode; unmapped addresses and unused bits return zero.
  always_comb begin
    unique case (ptr_reg)
      rtc_pkg::ADDR_CTRL2: rd_data = {3'b000, pulse_sel_reg, alarm_flag_reg,
                                       timer_flag_reg, alarm_ie_reg, timer_ie_reg};
      rtc_pkg::ADDR_SECONDS: rd_data = {low_voltage_reg, time_reg[0][6:0]};
      rtc_pkg::ADDR_MINUTES: rd_data = time_reg[1] & rtc_pkg::MINUTES_MASK;
      rtc_pkg::ADDR_HOURS: rd_data = time_reg[2] & rtc_pkg::HOURS_MASK;
      default: rd_data = 8'h00;
    endcase
  end

  // Two-wire slave with auto-incrementing address pointer.
  rtc_pkg::bus_state_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic rw_reg, ptr_phase_reg, ack_ok_reg, busy_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= rtc_pkg::ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      ptr_phase_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      busy_reg <= 1'b0;
      ptr_reg <= 8'h00;
      sda_oe <= 1'b0;
      wr_reg <= '0;
    end else begin
      wr_reg.valid <= 1'b0;
      if (bus_start) begin
        state_reg <= rtc_pkg::ST_ADDR;
        bit_cnt_reg <= 4'h0;
        busy_reg <= 1'b1;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= rtc_pkg::ST_IDLE;
        busy_reg <= 1'b0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        unique case (state_reg)
          rtc_pkg::ST_ADDR, rtc_pkg::ST_WR_BYTE, rtc_pkg::ST_RD_BYTE: begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          rtc_pkg::ST_RD_ACK: ack_ok_reg <= ~sda_s;
          default: ;
        endcase
      end else if (scl_fall) begin
        unique case (state_reg)
          rtc_pkg::ST_ADDR: begin
            if (bit_cnt_reg == rtc_pkg::BITS_PER_BYTE) begin
              if (shift_reg[7:1] == rtc_pkg::SLAVE_ADDR) begin
                state_reg <= rtc_pkg::ST_ACK_ADDR;
                rw_reg <= shift_reg[0];
                sda_oe <= 1'b1;
              end else begin
                state_reg <= rtc_pkg::ST_WAIT_STOP;
              end
            end
          end
          rtc_pkg::ST_ACK_ADDR: begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= rtc_pkg::ST_RD_BYTE;
              tx_reg <= rd_data;
              sda_oe <= ~rd_data[7];
            end else begin
              state_reg <= rtc_pkg::ST_WR_BYTE;
              ptr_phase_reg <= 1'b1;
              sda_oe <= 1'b0;
            end
          end
          rtc_pkg::ST_WR_BYTE: begin
            if (bit_cnt_reg == rtc_pkg::BITS_PER_BYTE) begin
              state_reg <= rtc_pkg::ST_ACK_WR;
              sda_oe <= 1'b1;
              ptr_phase_reg <= 1'b0;
              if (ptr_phase_reg) begin
                ptr_reg <= shift_reg;
              end else begin
                wr_reg <= '{valid: 1'b1, addr: ptr_reg, data: shift_reg};
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          rtc_pkg::ST_ACK_WR: begin
            state_reg <= rtc_pkg::ST_WR_BYTE;
            bit_cnt_reg <= 4'h0;
            sda_oe <= 1'b0;
          end
          rtc_pkg::ST_RD_BYTE: begin
            if (bit_cnt_reg == rtc_pkg::BITS_PER_BYTE) begin
              state_reg <= rtc_pkg::ST_RD_ACK;
              sda_oe <= 1'b0;
              ptr_reg <= ptr_reg + 8'h01;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe <= ~tx_reg[6];
            end
          end
          rtc_pkg::ST_RD_ACK: begin
            if (ack_ok_reg) begin
              state_reg <= rtc_pkg::ST_RD_BYTE;
              bit_cnt_reg <= 4'h0;
              tx_reg <= rd_data;
              sda_oe <= ~rd_data[7];
            end else begin
              state_reg <= rtc_pkg::ST_WAIT_STOP;
            end
          end
          rtc_pkg::ST_IDLE, rtc_pkg::ST_WAIT_STOP: ;
        endcase
      end
    end
  end

  assign sda_out = 1'b0;

  logic wr_ctrl;
  assign wr_ctrl = wr_reg.valid && (wr_reg.addr == rtc_pkg::ADDR_CTRL2);

  // Control bits; the unused upper bits are simply not stored.
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_sel_reg <= 1'b0;
      alarm_ie_reg <= 1'b0;
      timer_ie_reg <= 1'b0;
    end else if (wr_ctrl) begin
      pulse_sel_reg <= wr_reg.data[rtc_pkg::BIT_PULSE_SEL];
      alarm_ie_reg <= wr_reg.data[rtc_pkg::BIT_ALARM_IE];
      timer_ie_reg <= wr_reg.data[rtc_pkg::BIT_TIMER_IE];
    end
  end

  // Flags: a write ANDs, and a new event in the same cycle still wins.
  logic timer_accept;
  assign timer_accept = timer_done && (timer_count != rtc_pkg::COUNT_ZERO);

  always_ff @(posedge clk) begin
    if (rst) begin
      alarm_flag_reg <= 1'b0;
      timer_flag_reg <= 1'b0;
    end else begin
      alarm_flag_reg <= alarm_event |
        (alarm_flag_reg & (~wr_ctrl | wr_reg.data[rtc_pkg::BIT_ALARM_FLAG]));
      timer_flag_reg <= timer_accept |
        (timer_flag_reg & (~wr_ctrl | wr_reg.data[rtc_pkg::BIT_TIMER_FLAG]));
    end
  end

  // Pulse width chosen from source clock and loaded count.
  function automatic int unsigned pulse_width(input rtc_pkg::timer_src_e src,
                                              input logic count_is_one);
    unique case (src)
      rtc_pkg::SRC_4096HZ: pulse_width = count_is_one ? PULSE_8192_CYCLES : PULSE_4096_CYCLES;
      rtc_pkg::SRC_64HZ: pulse_width = count_is_one ? PULSE_128_CYCLES : PULSE_64_CYCLES;
      rtc_pkg::SRC_1HZ, rtc_pkg::SRC_1_60HZ: pulse_width = PULSE_64_CYCLES;
    endcase
  endfunction : pulse_width

  int unsigned pulse_cnt_reg;

  // Loaded on the same edge that sets the timer flag, so both rise together.
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_cnt_reg <= 0;
    end else if (timer_accept) begin
      pulse_cnt_reg <= pulse_width(timer_src, timer_count == rtc_pkg::COUNT_ONE);
    end else if (pulse_cnt_reg != 0) begin
      pulse_cnt_reg <= pulse_cnt_reg - 1;
    end
  end

  logic timer_irq, alarm_irq;
  assign timer_irq = timer_ie_reg & (pulse_sel_reg ? (pulse_cnt_reg != 0) : timer_flag_reg);
  assign alarm_irq = alarm_ie_reg & alarm_flag_reg;
  assign int_oe = alarm_irq | timer_irq;
  assign int_out = 1'b0;

  // Integrity flag: monitors set it, only a host write of zero clears it.
  logic wr_seconds;
  assign wr_seconds = wr_reg.valid && (wr_reg.addr == rtc_pkg::ADDR_SECONDS);

  always_ff @(posedge clk) begin
    if (rst) begin
      low_voltage_reg <= rtc_pkg::LOW_VOLTAGE_RESET;
    end else if (supply_low_s || osc_stopped_s) begin
      low_voltage_reg <= 1'b1;
    end else if (wr_seconds) begin
      low_voltage_reg <= wr_reg.data[rtc_pkg::BIT_LOW_VOLTAGE];
    end
  end

  // Second divider; clock-stop holds it cleared so counting restarts whole.
  int unsigned div_cnt_reg;
  logic tick;
  assign tick = (div_cnt_reg == TICK_CYCLES - 1);

  always_ff @(posedge clk) begin
    if (rst || clock_stop_s || tick) begin
      div_cnt_reg <= 0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1;
    end
  end

  // Only one tick can wait, so a bus access must finish within a second.
  logic pending_reg, step;
  assign step = ~busy_reg & ~clock_stop_s & (tick | pending_reg);

  always_ff @(posedge clk) begin
    if (rst || clock_stop_s) begin
      pending_reg <= 1'b0;
    end else if (busy_reg && tick) begin
      pending_reg <= 1'b1;
    end else if (step) begin
      pending_reg <= 1'b0;
    end
  end

  // Carry chain through seconds, minutes and hours.
  logic [rtc_pkg::TIME_STAGES:0] carry;
  logic [7:0] inc_value [rtc_pkg::TIME_STAGES];
  logic [rtc_pkg::TIME_STAGES-1:0] wrap;
  assign carry[0] = step;

  genvar i;
  generate
    for (i = 0; i < rtc_pkg::TIME_STAGES; i++) begin : g_time
      bcd_incr u_incr (
        .value(time_reg[i]),
        .limit(rtc_pkg::TIME_LIMIT[i]),
        .next_value(inc_value[i]),
        .wrap(wrap[i])
      );
      assign carry[i+1] = carry[i] & wrap[i];

      always_ff @(posedge clk) begin
        if (rst) begin
          time_reg[i] <= rtc_pkg::TIME_RESET;
        end else if (wr_reg.valid && (wr_reg.addr == rtc_pkg::TIME_ADDR[i])) begin
          time_reg[i] <= wr_reg.data & rtc_pkg::TIME_MASK[i];
        end else if (carry[i]) begin
          time_reg[i] <= inc_value[i];
        end
      end
    end
  endgenerate

  property p_level_irq;
    @(posedge clk) disable iff (rst)
      (!pulse_sel_reg && timer_ie_reg && timer_flag_reg) |-> int_oe;
  endproperty
  a_level_irq: assert property (p_level_irq) else $error("level timer irq missing");

  property p_alarm_hold;
    @(posedge clk) disable iff (rst) (alarm_flag_reg && alarm_ie_reg) |-> int_oe;
  endproperty
  a_alarm_hold: assert property (p_alarm_hold) else $error("alarm irq not held");

  property p_alarm_set;
    @(posedge clk) disable iff (rst) alarm_event |=> alarm_flag_reg;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("alarm flag not set");

  property p_flag_clear;
    @(posedge clk) disable iff (rst)
      (wr_ctrl && !wr_reg.data[rtc_pkg::BIT_TIMER_FLAG] && !timer_done) |=> !timer_flag_reg;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("timer flag not cleared");

  property p_pulse_together;
    @(posedge clk) disable iff (rst)
      ($rose(timer_flag_reg) && pulse_sel_reg && timer_ie_reg) |-> int_oe;
  endproperty
  a_pulse_together: assert property (p_pulse_together) else $error("pulse late");

  property p_count_zero;
    @(posedge clk) disable iff (rst)
      (timer_done && timer_count == rtc_pkg::COUNT_ZERO && !timer_flag_reg)
      |=> !timer_flag_reg;
  endproperty
  a_count_zero: assert property (p_count_zero) else $error("stopped timer fired");

  property p_width_64;
    @(posedge clk) disable iff (rst)
      (timer_accept && timer_src == rtc_pkg::SRC_64HZ && timer_count > rtc_pkg::COUNT_ONE)
      |=> pulse_cnt_reg == PULSE_64_CYCLES;
  endproperty
  a_width_64: assert property (p_width_64) else $error("wrong pulse width");

  property p_vl_startup;
    @(posedge clk) disable iff (rst) $fell(rst) |-> low_voltage_reg;
  endproperty
  a_vl_startup: assert property (p_vl_startup) else $error("integrity flag not set");

  property p_vl_supply;
    @(posedge clk) disable iff (rst) supply_low_s |=> low_voltage_reg ##1 low_voltage_reg;
  endproperty
  a_vl_supply: assert property (p_vl_supply) else $error("low supply not flagged");

  property p_blocked;
    @(posedge clk) disable iff (rst)
      (busy_reg && !wr_reg.valid) |=> $stable(time_reg[0]);
  endproperty
  a_blocked: assert property (p_blocked) else $error("count during access");

  property p_sec_roll;
    @(posedge clk) disable iff (rst)
      (step && time_reg[0] == 8'h59 && !wr_reg.valid) |=> time_reg[0] == 8'h00;
  endproperty
  a_sec_roll: assert property (p_sec_roll) else $error("seconds roll wrong");

endmodule : rtc_core

// >>> i2c_host_model.sv
module i2c_host_model (
  // Clock
  input wire logic clk,
  // Wire levels
  input wire logic sda_oe,
  input wire logic sda_drv,
  output logic scl,
  output logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sda_rel;
  int nacks;
  // Pull-up on the data line: it reads high unless some party pulls it low.
  // While the device drives the line, the level it drives is what the host sees.
  assign sda = sda_rel & (~sda_oe | sda_drv);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    nacks = 0;
  end
  task automatic q();
    repeat (4) @(posedge clk);
  endtask : q
  // Data moves a quarter phase after the clock falls, never on the same edge.
  task automatic put_bit(input logic b);
    q();
    sda_rel <= b;
    q();
    scl <= 1'b1;
    q();
    q();
    scl <= 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    q();
    sda_rel <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    b = sda;
    q();
    scl <= 1'b0;
  endtask : get_bit
  task automatic start();
    sda_rel <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sda_rel <= 1'b0;
    q();
    scl <= 1'b0;
  endtask : start
  task automatic stop();
    q();
    sda_rel <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    sda_rel <= 1'b1;
    q();
  endtask : stop
  task automatic send(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    if (a !== 1'b0) nacks++;
  endtask : send
  task automatic access(input logic [7:0] a, input logic [7:0] w [4], input int nw, input int nr,
                        output logic [7:0] r [4]);
    start();
    send({rtc_pkg::SLAVE_ADDR, 1'b0});
    send(a);
    for (int i = 0; i < nw; i++) begin
      if (a == rtc_pkg::ADDR_CTRL2) send(w[i] & rtc_pkg::CTRL2_MASK);
      else send(w[i]);
    end
    if (nr > 0) begin
      if (nw > 0) begin
        start();
        send({rtc_pkg::SLAVE_ADDR, 1'b0});
        send(a);
      end
      start();
      send({rtc_pkg::SLAVE_ADDR, 1'b1});
      for (int i = 0; i < nr; i++) begin
        for (int j = 7; j >= 0; j--) get_bit(r[i][j]);
        put_bit(i == nr - 1);
      end
    end
    stop();
  endtask : access
endmodule : i2c_host_model

// >>> rtc_core_test.sv
module rtc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, scl, sda, sda_oe, int_oe, alarm_event, timer_done;
  logic supply_low, osc_stopped, clock_stop, sda_out, int_out;
  rtc_pkg::timer_src_e timer_src;
  logic [7:0] timer_count, d, e, seed;
  logic [7:0] r [4];
  int err_count = 0;
  int checks = 0;
  int w;
  rtc_core #(.TICK_CYCLES(50), .PULSE_8192_CYCLES(3), .PULSE_4096_CYCLES(5),
    .PULSE_128_CYCLES(7), .PULSE_64_CYCLES(9)) DUT (.clk(clk), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .int_oe(int_oe),
    .alarm_event(alarm_event), .timer_done(timer_done), .timer_src(timer_src),
    .timer_count(timer_count), .supply_low(supply_low), .osc_stopped(osc_stopped),
    .clock_stop(clock_stop));
  i2c_host_model host (.clk(clk), .sda_oe(sda_oe), .sda_drv(sda_out), .scl(scl), .sda(sda));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic int exp_w(input int s, input logic [7:0] n);
    if (s == 0) return (n == 8'h01) ? 3 : 5;
    if (s == 1) return (n == 8'h01) ? 7 : 9;
    return 9;
  endfunction : exp_w
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk_int(input int got, input int exp);
    checks++;
    if (got != exp) begin
      err_count++;
      $display("MISMATCH t=%0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_int
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.access(a, '{v, 8'h00, 8'h00, 8'h00}, 1, 0, r);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    host.access(a, '{8'h00, 8'h00, 8'h00, 8'h00}, 0, 1, r);
    v = r[0];
  endtask : rd
  task automatic trig(input bit alarm);
    @(posedge clk);
    if (alarm) alarm_event <= 1'b1;
    else timer_done <= 1'b1;
    @(posedge clk);
    alarm_event <= 1'b0;
    timer_done <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : trig
  task automatic pin(input logic exp);
    @(negedge clk);
    chk8({6'h00, int_out, int_oe}, {7'h00, exp});
  endtask : pin
  // Counts the cycles the interrupt pin stays active after one end-of-count.
  task automatic pulse_w(output int cnt);
    @(posedge clk);
    timer_done <= 1'b1;
    @(posedge clk);
    timer_done <= 1'b0;
    cnt = 0;
    repeat (30) @(negedge clk) if (int_oe !== 1'b0) cnt++;
  endtask : pulse_w
  task automatic finish_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    alarm_event = 1'b0;
    timer_done = 1'b0;
    timer_src = rtc_pkg::SRC_4096HZ;
    timer_count = 8'h00;
    supply_low = 1'b0;
    osc_stopped = 1'b0;
    clock_stop = 1'b0;
    seed = 8'h25;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    host.access(rtc_pkg::ADDR_CTRL2, '{8'h00, 8'h00, 8'h00, 8'h00}, 0, 4, r);
    chk8(r[0], 8'h00);
    chk8(r[1], 8'h80);
    chk8(r[2] | r[3], 8'h00);
    wr(rtc_pkg::ADDR_SECONDS, 8'h00);
    rd(rtc_pkg::ADDR_SECONDS, d);
    chk8(d & 8'h80, 8'h00);
    supply_low <= 1'b1;
    repeat (6) @(posedge clk);
    supply_low <= 1'b0;
    rd(rtc_pkg::ADDR_SECONDS, d);
    chk8(d & 8'h80, 8'h80);
    wr(rtc_pkg::ADDR_SECONDS, 8'h00);
    osc_stopped <= 1'b1;
    repeat (6) @(posedge clk);
    osc_stopped <= 1'b0;
    rd(rtc_pkg::ADDR_SECONDS, d);
    chk8(d & 8'h80, 8'h80);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      host.access(rtc_pkg::ADDR_MINUTES, '{seed, 8'h00, 8'h00, 8'h00}, 1, 1, r);
      chk8(r[0], seed & 8'h7F);
      host.access(rtc_pkg::ADDR_HOURS, '{seed, 8'h00, 8'h00, 8'h00}, 1, 1, r);
      chk8(r[0], seed & 8'h3F);
      host.access(8'h10, '{seed, 8'h00, 8'h00, 8'h00}, 1, 1, r);
      chk8(r[0], 8'h00);
    end
    // Ticks pass during this long access; none may show until it ends.
    host.access(rtc_pkg::ADDR_SECONDS, '{8'h59, 8'h59, 8'h23, 8'h00}, 3, 3, r);
    chk8(r[0], 8'h59);
    chk8(r[1], 8'h59);
    chk8(r[2], 8'h23);
    host.access(rtc_pkg::ADDR_SECONDS, '{8'h00, 8'h00, 8'h00, 8'h00}, 0, 3, r);
    chk8({7'h00, r[0] <= 8'h01}, 8'h01);
    chk8(r[1], 8'h00);
    chk8(r[2], 8'h00);
    clock_stop <= 1'b1;
    rd(rtc_pkg::ADDR_SECONDS, d);
    repeat (200) @(posedge clk);
    rd(rtc_pkg::ADDR_SECONDS, e);
    chk8(e, d);
    clock_stop <= 1'b0;
    wr(rtc_pkg::ADDR_CTRL2, 8'h01);
    timer_src <= rtc_pkg::SRC_64HZ;
    timer_count <= 8'h03;
    trig(1'b0);
    pin(1'b1);
    repeat (30) @(posedge clk);
    pin(1'b1);
    wr(rtc_pkg::ADDR_CTRL2, 8'h05);
    pin(1'b1);
    wr(rtc_pkg::ADDR_CTRL2, 8'h01);
    pin(1'b0);
    timer_count <= 8'h00;
    trig(1'b0);
    rd(rtc_pkg::ADDR_CTRL2, d);
    chk8(d, 8'h01);
    timer_count <= 8'h02;
    wr(rtc_pkg::ADDR_CTRL2, 8'h10);
    pulse_w(w);
    chk_int(w, 0);
    trig(1'b1);
    pin(1'b0);
    rd(rtc_pkg::ADDR_CTRL2, d);
    chk8(d, 8'h1C);
    wr(rtc_pkg::ADDR_CTRL2, 8'h1A);
    pin(1'b1);
    wr(rtc_pkg::ADDR_CTRL2, 8'h12);
    pin(1'b0);
    wr(rtc_pkg::ADDR_CTRL2, 8'h11);
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 2; k++) begin
        seed = lfsr(seed);
        d = k ? ({seed[7:1], 1'b0} | 8'h02) : 8'h01;
        timer_src <= rtc_pkg::timer_src_e'(s);
        timer_count <= d;
        pulse_w(w);
        chk_int(w, exp_w(s, d));
        wr(rtc_pkg::ADDR_CTRL2, 8'h11);
      end
    end
    chk_int(host.nacks, 0);
    finish_test();
  end
endmodule : rtc_core_test
